// *** serial_port_pkg.sv ***
// shared constants and types for the buffered serial port
package serial_port_pkg;
    localparam int          DATA_BITS       = 8;
    localparam int          DIV_WIDTH       = 16;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          SOFT_MAX_BPS    = 19200;
    localparam int          HARD_MAX_BPS    = 8_000_000;
    // least clocks per bit
    localparam int          MIN_DIV         = CLK_HZ / HARD_MAX_BPS;
    localparam logic [15:0] DEFAULT_DIV     = 16'h0438;
    localparam int          RX_DEPTH        = 16;
    localparam int          TX_DEPTH        = 16;
    localparam logic        LINE_IDLE       = 1'b1;
    localparam logic        START_LEVEL     = 1'b0;
    localparam logic        STOP_LEVEL      = 1'b1;
    localparam logic        FC_STOP         = 1'b0;
    localparam logic        FC_GO           = 1'b1;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;
endpackage

// *** char_fifo_if.sv ***
// character fifo push, pop and status signals
`timescale 1ns/1ps
interface char_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
);
    localparam int CW = $clog2(DEPTH + 1);
    logic             flush;
    logic             push;
    logic             pop;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rdata;
    logic [CW-1:0]    count;
    logic             full;
    logic             empty;
    modport owner (output flush, output push, output pop, output wdata,
                   input rdata, input count, input full, input empty);
    modport store (input flush, input push, input pop, input wdata,
                   output rdata, output count, output full, output empty);
endinterface

// *** char_fifo.sv ***
// character fifo memory with registered head output and occupancy count
`timescale 1ns/1ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic    i_sys_clk,
    input  wire logic    i_rst_n,
    char_fifo_if.store   fifo
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic             do_pop;
    logic             do_push;
    logic [AW-1:0]    rd_ptr_next;

    assign fifo.full  = (count_reg == CW'(DEPTH));
    assign fifo.empty = (count_reg == '0);
    assign fifo.count = count_reg;
    assign do_pop     = fifo.pop && !fifo.empty;
    // a full store takes a push only alongside a pop
    assign do_push    = fifo.push && (!fifo.full || do_pop);
    assign rd_ptr_next = do_pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;

    always_ff @(posedge i_sys_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= fifo.wdata;
        end
    end

    // registered head, bypassing a write to its slot
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fifo.rdata <= '0;
        end else if (do_push && wr_ptr_reg == rd_ptr_next) begin
            fifo.rdata <= fifo.wdata;
        end else begin
            fifo.rdata <= mem[rd_ptr_next];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (fifo.flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= CW'(count_reg + CW'(do_push) - CW'(do_pop));
        end
    end
endmodule

// *** buffered_serial_port.sv ***
// buffered asynchronous serial port with flow control and console mirroring
// ==========
`timescale 1ns/1ps
module buffered_serial_port
    import serial_port_pkg::*;
#(
    parameter int          RX_DEPTH_P  = RX_DEPTH,
    parameter int          TX_DEPTH_P  = TX_DEPTH,
    parameter logic        SOFT_TIMED  = 1'b0,
    localparam int         RCW         = $clog2(RX_DEPTH_P + 1),
    localparam int         TCW         = $clog2(TX_DEPTH_P + 1)
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_open,
    input  wire logic                 i_close,
    input  wire logic                 i_open_console_mirror_mode,
    input  wire logic                 i_console_taken,
    input  wire logic                 i_flow_control_enable,
    input  wire logic [DIV_WIDTH-1:0] i_divisor,
    input  wire logic                 i_prog_run_clear,
    input  wire logic                 i_tx_valid,
    input  wire logic [7:0]           i_tx_data,
    output logic                      o_tx_ready,
    input  wire logic                 i_video_valid,
    input  wire logic [7:0]           i_video_data,
    output logic                      o_video_ready,
    input  wire logic                 i_rd_req,
    input  wire logic [RCW-1:0]       i_rd_max,
    input  wire logic                 i_rd_pop,
    output logic [RCW-1:0]            o_rd_grant,
    output logic                      o_rd_done,
    output logic [7:0]                o_rx_data,
    output logic                      o_rx_data_valid,
    output logic                      o_key_valid,
    output logic [7:0]                o_key_data,
    input  wire logic                 i_key_ready,
    output logic [RCW-1:0]            o_rx_waiting_count,
    output logic                      o_rx_empty,
    output logic [TCW-1:0]            o_tx_free_space,
    input  wire logic [RCW-1:0]       i_event_level,
    input  wire logic                 i_event_enable,
    output logic                      o_rx_level_event,
    output logic                      o_port_open,
    output logic                      o_console_mirror_mode,
    output logic                      o_pin_lock,
    input  wire logic                 i_rx_pin,
    output logic                      o_tx_pin,
    output logic                      o_tx_oe,
    input  wire logic                 i_cts_pin,
    output logic                      o_rts_pin,
    output logic                      o_rts_oe
);
    char_fifo_if #(.WIDTH(8), .DEPTH(RX_DEPTH_P)) rxq ();
    char_fifo_if #(.WIDTH(8), .DEPTH(TX_DEPTH_P)) txq ();

    char_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH_P)) u_rx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .fifo      (rxq.store)
    );
    char_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH_P)) u_tx_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .fifo      (txq.store)
    );

    // ==========
    // port open / close / console control
    // ==========
    logic                 open_reg;
    logic                 console_reg;
    logic                 fc_reg;
    logic [DIV_WIDTH-1:0] div_reg;
    logic                 close_now;
    logic [DIV_WIDTH-1:0] div_limited;

    // clamp the divisor to the port's top rate
    assign div_limited = SOFT_TIMED ?
        ((i_divisor < DIV_WIDTH'(CLK_HZ / SOFT_MAX_BPS)) ?
            DIV_WIDTH'(CLK_HZ / SOFT_MAX_BPS) : i_divisor) :
        ((i_divisor < DIV_WIDTH'(MIN_DIV)) ? DIV_WIDTH'(MIN_DIV) : i_divisor);

    assign close_now = open_reg && (i_close ||
                       (i_prog_run_clear && !console_reg));

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            open_reg    <= 1'b0;
            console_reg <= 1'b0;
            fc_reg      <= 1'b0;
            div_reg     <= DEFAULT_DIV;
        end else if (close_now) begin
            open_reg    <= 1'b0;
            console_reg <= 1'b0;
            fc_reg      <= 1'b0;
        end else if (i_open && !open_reg &&
                     !(i_open_console_mirror_mode && i_console_taken)) begin
            open_reg    <= 1'b1;
            console_reg <= i_open_console_mirror_mode;
            fc_reg      <= i_flow_control_enable;
            div_reg     <= div_limited;
        end
    end

    assign o_port_open           = open_reg;
    assign o_console_mirror_mode = console_reg;
    assign o_pin_lock            = open_reg;
    assign o_tx_oe               = open_reg;
    assign o_rts_oe              = open_reg && fc_reg;
    assign rxq.flush             = close_now;
    assign txq.flush             = close_now;

    // ==========
    // rx and cts pin synchronisers
    // ==========
    logic [1:0] rx_sync_reg;
    logic [1:0] cts_sync_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_sync_reg  <= {2{LINE_IDLE}};
            cts_sync_reg <= {2{FC_STOP}};
        end else begin
            rx_sync_reg  <= {rx_sync_reg[0], i_rx_pin};
            cts_sync_reg <= {cts_sync_reg[0], i_cts_pin};
        end
    end

    // ==========
    // transmitter
    // ==========
    tx_state_t            tx_state_reg;
    logic [DIV_WIDTH-1:0] tx_cnt_reg;
    logic [2:0]           tx_bit_reg;
    logic [7:0]           tx_shift_reg;
    logic                 tx_tick;
    logic                 tx_may_start;

    assign tx_tick      = (tx_cnt_reg == div_reg - 1'b1);
    assign tx_may_start = !fc_reg || (cts_sync_reg[1] == FC_GO);
    assign txq.pop      = open_reg && tx_state_reg == TX_IDLE && !txq.empty && tx_may_start;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= '0;
            tx_bit_reg   <= '0;
            tx_shift_reg <= '0;
            o_tx_pin     <= LINE_IDLE;
        end else if (!open_reg) begin
            tx_state_reg <= TX_IDLE;
            o_tx_pin     <= LINE_IDLE;
        end else begin
            tx_cnt_reg <= (tx_state_reg == TX_IDLE || tx_tick) ? '0 : tx_cnt_reg + 1'b1;
            unique case (tx_state_reg)
                TX_IDLE: begin
                    o_tx_pin <= LINE_IDLE;
                    if (txq.pop) begin
                        tx_shift_reg <= txq.rdata;
                        tx_state_reg <= TX_START;
                        o_tx_pin     <= START_LEVEL;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        o_tx_pin     <= tx_shift_reg[0];
                        tx_bit_reg   <= '0;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_reg == 3'(DATA_BITS - 1)) begin
                            o_tx_pin     <= STOP_LEVEL;
                            tx_state_reg <= TX_STOP;
                        end else begin
                            o_tx_pin     <= tx_shift_reg[tx_bit_reg + 1'b1];
                            tx_bit_reg   <= tx_bit_reg + 1'b1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // host writes win over mirror writes
    assign o_tx_ready    = open_reg && !txq.full;
    assign o_video_ready = !console_reg || (!txq.full && !i_tx_valid);
    assign txq.push      = open_reg && !txq.full &&
                           (i_tx_valid || (console_reg && i_video_valid));
    assign txq.wdata     = i_tx_valid ? i_tx_data : i_video_data;
    assign o_tx_free_space = TCW'(TX_DEPTH_P) - txq.count;

    // ==========
    // receiver
    // ==========
    rx_state_t            rx_state_reg;
    logic [DIV_WIDTH-1:0] rx_cnt_reg;
    logic [2:0]           rx_bit_reg;
    logic [7:0]           rx_shift_reg;
    logic                 rx_done;
    logic                 rx_mid;
    logic                 rx_line;

    assign rx_line = rx_sync_reg[1];
    assign rx_mid  = (rx_cnt_reg == (div_reg >> 1));

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= '0;
            rx_bit_reg   <= '0;
            rx_shift_reg <= '0;
            rx_done      <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!open_reg) begin
                rx_state_reg <= RX_IDLE;
            end else begin
                rx_cnt_reg <= (rx_cnt_reg == div_reg - 1'b1) ? '0 : rx_cnt_reg + 1'b1;
                unique case (rx_state_reg)
                    RX_IDLE: begin
                        rx_cnt_reg <= '0;
                        if (rx_line == START_LEVEL) begin
                            rx_state_reg <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_mid) begin
                            rx_state_reg <= (rx_line == START_LEVEL) ? RX_DATA : RX_IDLE;
                            rx_bit_reg   <= '0;
                        end
                    end
                    RX_DATA: begin
                        if (rx_mid) begin
                            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                            rx_bit_reg   <= rx_bit_reg + 1'b1;
                            if (rx_bit_reg == 3'(DATA_BITS - 1)) begin
                                rx_state_reg <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_mid) begin
                            rx_done      <= (rx_line == STOP_LEVEL);
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // a push into a full buffer pops the oldest
    assign rxq.push  = rx_done && open_reg;
    assign rxq.wdata = rx_shift_reg;
    assign rxq.pop   = (rxq.push && rxq.full) ||
                       (console_reg ? (o_key_valid && i_key_ready) :
                                      (o_rx_data_valid && i_rd_pop));
    // ask the peer to pause while the buffer is full
    assign o_rts_pin = (fc_reg && rxq.full) ? FC_STOP : FC_GO;

    // ==========
    // host read side, console keys and status
    // ==========
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_grant <= '0;
            o_rd_done  <= 1'b0;
        end else begin
            o_rd_done <= i_rd_req;
            if (i_rd_req) begin
                o_rd_grant <= (i_rd_max < rxq.count) ? i_rd_max : rxq.count;
            end
        end
    end

    assign o_rx_data          = rxq.rdata;
    assign o_rx_data_valid    = !console_reg && !rxq.empty;
    assign o_key_data         = rxq.rdata;
    assign o_key_valid        = console_reg && !rxq.empty;
    assign o_rx_waiting_count = rxq.count;
    assign o_rx_empty         = rxq.empty;
    assign o_rx_level_event   = open_reg && i_event_enable &&
                                (rxq.count >= i_event_level) && (i_event_level != '0);
endmodule

// *** buffered_serial_port_sva.sv ***
// assertions on the serial port's top-level ports
`timescale 1ns/1ps
module buffered_serial_port_sva
    import serial_port_pkg::*;
#(
    parameter int  RX_DEPTH_P = RX_DEPTH,
    parameter int  TX_DEPTH_P = TX_DEPTH,
    localparam int RCW        = $clog2(RX_DEPTH_P + 1),
    localparam int TCW        = $clog2(TX_DEPTH_P + 1)
) (
    input wire logic           i_sys_clk,
    input wire logic           i_rst_n,
    input wire logic           i_close,
    input wire logic           i_prog_run_clear,
    input wire logic           i_rd_req,
    input wire logic [RCW-1:0] i_rd_max,
    input wire logic           i_cts_pin,
    input wire logic [RCW-1:0] i_event_level,
    input wire logic           i_event_enable,
    input wire logic           o_tx_ready,
    input wire logic [RCW-1:0] o_rd_grant,
    input wire logic           o_rd_done,
    input wire logic [RCW-1:0] o_rx_waiting_count,
    input wire logic           o_rx_empty,
    input wire logic [TCW-1:0] o_tx_free_space,
    input wire logic           o_rx_level_event,
    input wire logic           o_port_open,
    input wire logic           o_console_mirror_mode,
    input wire logic           o_pin_lock,
    input wire logic           o_tx_oe,
    input wire logic           o_rts_pin,
    input wire logic           o_rts_oe,
    input wire logic           o_key_valid
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ========
    // properties
    property p_pins_follow_open;
        o_tx_oe == o_port_open && o_pin_lock == o_port_open;
    endproperty
    property p_empty_flag;
        o_rx_empty == (o_rx_waiting_count == 0);
    endproperty
    property p_read_grant;
        i_rd_req |=> o_rd_done && o_rd_grant == (($past(i_rd_max) < $past(o_rx_waiting_count))
            ? $past(i_rd_max) : $past(o_rx_waiting_count));
    endproperty
    property p_tx_ready;
        o_tx_ready == (o_port_open && o_tx_free_space != 0);
    endproperty
    property p_rts_level;
        o_rts_oe |-> o_rts_pin == (o_rx_waiting_count != RCW'(RX_DEPTH_P));
    endproperty
    property p_cts_hold;
        (o_rts_oe && !i_cts_pin) [*4] |-> o_tx_free_space <= $past(o_tx_free_space);
    endproperty
    property p_close_flush;
        i_close && o_port_open |=> !o_port_open && o_rx_empty && !o_tx_ready;
    endproperty
    property p_run_closes;
        i_prog_run_clear && o_port_open && !o_console_mirror_mode |=> !o_port_open;
    endproperty
    property p_console_kept;
        i_prog_run_clear && o_console_mirror_mode && !i_close |=> o_port_open;
    endproperty
    property p_level_event;
        o_port_open && i_event_enable && i_event_level != 0
            |-> o_rx_level_event == (o_rx_waiting_count >= i_event_level);
    endproperty
    // ========
    // assertions and covers
    a_pins_follow_open: assert property (p_pins_follow_open)
        else $error("pin enable wrong");
    a_empty_flag: assert property (p_empty_flag)
        else $error("receive empty flag wrong");
    a_read_grant: assert property (p_read_grant)
        else $error("read grant wrong");
    a_tx_ready: assert property (p_tx_ready)
        else $error("write ready wrong");
    a_rts_level: assert property (p_rts_level)
        else $error("rts level wrong");
    a_cts_hold: assert property (p_cts_hold)
        else $error("frame under stop");
    a_close_flush: assert property (p_close_flush)
        else $error("close did not flush");
    a_run_closes: assert property (p_run_closes)
        else $error("run did not close port");
    a_console_kept: assert property (p_console_kept)
        else $error("console port closed by run");
    a_level_event: assert property (p_level_event)
        else $error("level event wrong");
    c_rx_full: cover property (o_rx_waiting_count == RCW'(RX_DEPTH_P));
    c_console_run: cover property (i_prog_run_clear && o_console_mirror_mode);
    c_key: cover property (o_key_valid);
endmodule

bind buffered_serial_port buffered_serial_port_sva #(
    .RX_DEPTH_P (RX_DEPTH_P),
    .TX_DEPTH_P (TX_DEPTH_P)
) buffered_serial_port_sva_inst (.*);

// *** serial_peer_model.sv ***
// remote terminal model
`timescale 1ns/1ps
module serial_peer_model #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic i_sys_clk,
    input  wire logic i_line,
    output logic      o_line,
    output logic      o_cts
);
    logic [7:0] got_q[$];
    int         bad_frames = 0;
    initial begin
        o_line = 1'h1;
        o_cts  = 1'h1;
    end
    // ========
    // sender
    task automatic send_char(input logic [7:0] ch);
        @(negedge i_sys_clk);
        o_line = 1'h0;
        repeat (BIT_CYCLES) @(negedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            o_line = ch[i];
            repeat (BIT_CYCLES) @(negedge i_sys_clk);
        end
        o_line = 1'h1;
        repeat (BIT_CYCLES) @(negedge i_sys_clk);
    endtask
    // ========
    // receiver, mid-bit sampling
    always begin : rx_frame
        logic [7:0] ch;
        @(negedge i_line);
        repeat (BIT_CYCLES / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge i_sys_clk);
            ch[i] = i_line;
        end
        repeat (BIT_CYCLES) @(posedge i_sys_clk);
        if (i_line === 1'h1) begin
            got_q.push_back(ch);
        end else begin
            bad_frames++;
        end
    end
endmodule

// *** buffered_serial_port_tb_top.sv ***
// testbench for the buffered serial port
`timescale 1ns/1ps
module buffered_serial_port_tb_top;
    import serial_port_pkg::*;
    localparam int DEPTH = 4;
    localparam int BITC  = 16;
    localparam int CW    = $clog2(DEPTH + 1);
    logic          i_sys_clk = 1'h0, i_rst_n = 1'h0;
    logic          i_open = 1'h0, i_close = 1'h0, i_prog_run_clear = 1'h0;
    logic          i_open_console_mirror_mode = 1'h0, i_console_taken = 1'h0;
    logic          i_flow_control_enable = 1'h0, i_tx_valid = 1'h0, i_video_valid = 1'h0;
    logic          i_rd_req = 1'h0, i_rd_pop = 1'h0, i_key_ready = 1'h0;
    logic          i_event_enable = 1'h0;
    logic [15:0]   i_divisor = 16'h0010;
    logic [7:0]    i_tx_data = 8'h00, i_video_data = 8'h00, o_rx_data, o_key_data;
    logic [CW-1:0] i_rd_max = '0, i_event_level = '0;
    logic [CW-1:0] o_rd_grant, o_rx_waiting_count, o_tx_free_space;
    logic          o_tx_ready, o_video_ready, o_rd_done, o_rx_data_valid, o_key_valid;
    logic          o_rx_empty, o_rx_level_event, o_port_open, o_console_mirror_mode;
    logic          o_pin_lock, o_tx_pin, o_tx_oe, o_rts_pin, o_rts_oe, i_rx_pin, i_cts_pin;
    int            num_errors = 0;
    int            num_checks = 0;

    buffered_serial_port #(.RX_DEPTH_P(DEPTH), .TX_DEPTH_P(DEPTH)) buffered_serial_port_inst (.*);
    serial_peer_model #(.BIT_CYCLES(BITC)) serial_peer_model_inst (
        .i_sys_clk (i_sys_clk),
        .i_line    (o_tx_pin),
        .o_line    (i_rx_pin),
        .o_cts     (i_cts_pin)
    );
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // ========
    // shared tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_sys_clk);
        s = 1'h1;
        @(negedge i_sys_clk);
        s = 1'h0;
    endtask
    task automatic open_port(input logic con, input logic fc);
        i_open_console_mirror_mode = con;
        i_flow_control_enable = fc;
        pulse(i_open);
    endtask
    task automatic write_chars(input logic [7:0] q[$]);
        @(negedge i_sys_clk);
        foreach (q[i]) begin
            i_tx_valid = 1'h1;
            i_tx_data = q[i];
            while (o_tx_ready !== 1'h1) @(negedge i_sys_clk);
            @(negedge i_sys_clk);
        end
        i_tx_valid = 1'h0;
    endtask
    task automatic wait_peer(input int n);
        while (serial_peer_model_inst.got_q.size() < n) @(negedge i_sys_clk);
    endtask
    task automatic read_req(input logic [CW-1:0] n, input logic [CW-1:0] exp);
        @(negedge i_sys_clk);
        i_rd_max = n;
        i_rd_req = 1'h1;
        @(negedge i_sys_clk);
        i_rd_req = 1'h0;
        check(8'(o_rd_done), 8'h01, "read done");
        check(8'(o_rd_grant), 8'(exp), "read grant");
    endtask
    task automatic pop_check(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(negedge i_sys_clk);
            check(8'(o_rx_data_valid), 8'h01, "head valid");
            check(o_rx_data, q[i], "head char");
            i_rd_pop = 1'h1;
            @(negedge i_sys_clk);
            i_rd_pop = 1'h0;
        end
    endtask
    // ========
    // scenarios
    task automatic t_transmit;
        check(8'(o_rx_empty), 8'h01, "empty at reset");
        check(8'({o_tx_pin, o_tx_oe, o_tx_ready}), 8'h04, "idle at reset");
        open_port(1'h0, 1'h1);
        check(8'({o_tx_oe, o_pin_lock}), 8'h03, "pins taken");
        check(8'(o_tx_free_space), 8'(DEPTH), "free after open");
        write_chars('{8'hA5, 8'h3C, 8'h01});
        wait_peer(3);
        check(serial_peer_model_inst.got_q[0], 8'hA5, "sent 0");
        check(serial_peer_model_inst.got_q[2], 8'h01, "sent 2");
        check(8'(serial_peer_model_inst.bad_frames), 8'h00, "stop bits");
        serial_peer_model_inst.got_q.delete();
        $display("test transmit done");
    endtask
    task automatic t_flow_and_close;
        serial_peer_model_inst.o_cts = 1'h0;
        write_chars('{8'h5A, 8'h11, 8'h22, 8'h33});
        repeat (300) @(negedge i_sys_clk);
        check(8'(serial_peer_model_inst.got_q.size()), 8'h00, "held by cts");
        check(8'({o_tx_ready, o_tx_free_space}), 8'h00, "tx full");
        pulse(i_close);
        serial_peer_model_inst.o_cts = 1'h1;
        check(8'({o_port_open, o_tx_oe, o_pin_lock}), 8'h00, "pins released");
        open_port(1'h0, 1'h1);
        repeat (300) @(negedge i_sys_clk);
        check(8'(serial_peer_model_inst.got_q.size()), 8'h00, "tx flushed");
        check(8'(o_tx_free_space), 8'(DEPTH), "free after reopen");
        $display("test flow and close done");
    endtask
    task automatic t_receive;
        i_event_level = 3'h2;
        i_event_enable = 1'h1;
        for (int i = 1; i <= 3; i++) serial_peer_model_inst.send_char(8'(8'h11 * i));
        repeat (4) @(negedge i_sys_clk);
        check(8'(o_rx_waiting_count), 8'h03, "waiting count");
        check(8'(o_rx_level_event), 8'h01, "level event");
        read_req(3'h5, 3'h3);
        read_req(3'h2, 3'h2);
        pop_check('{8'h11, 8'h22, 8'h33});
        check(8'(o_rx_empty), 8'h01, "empty after drain");
        read_req(3'h3, 3'h0);
        for (int i = 0; i <= DEPTH; i++) serial_peer_model_inst.send_char(8'h40 + 8'(i));
        repeat (4) @(negedge i_sys_clk);
        check(8'(o_rx_waiting_count), 8'(DEPTH), "full count");
        check(8'(o_rts_pin), 8'h00, "rts stop when full");
        pop_check('{8'h41, 8'h42, 8'h43, 8'h44});
        check(8'(o_rts_pin), 8'h01, "rts go");
        $display("test receive done");
    endtask
    task automatic t_console;
        pulse(i_close);
        i_console_taken = 1'h1;
        open_port(1'h1, 1'h0);
        check(8'(o_port_open), 8'h00, "console refused");
        i_console_taken = 1'h0;
        open_port(1'h1, 1'h0);
        check(8'(o_console_mirror_mode), 8'h01, "console on");
        @(negedge i_sys_clk);
        i_video_valid = 1'h1;
        i_video_data = 8'h56;
        while (o_video_ready !== 1'h1) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        i_video_valid = 1'h0;
        wait_peer(1);
        check(serial_peer_model_inst.got_q[0], 8'h56, "video mirrored");
        pulse(i_prog_run_clear);
        check(8'(o_port_open), 8'h01, "console survives run");
        serial_peer_model_inst.send_char(8'h71);
        while (o_key_valid !== 1'h1) @(negedge i_sys_clk);
        check(o_key_data, 8'h71, "key delivered");
        pulse(i_key_ready);
        pulse(i_close);
        open_port(1'h0, 1'h0);
        pulse(i_prog_run_clear);
        check(8'(o_port_open), 8'h00, "run closes port");
        $display("test console done");
    endtask
    // ========
    // sequence, watchdog and verdict
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'h1;
        t_transmit();
        t_flow_and_close();
        t_receive();
        t_console();
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        num_errors++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        tally_and_finish();
    end
endmodule
